// >>> io_command_decoder_map.svh
// Command codes, control and status bit positions and reset values of the command decoder.
`ifndef IO_COMMAND_DECODER_MAP_SVH
`define IO_COMMAND_DECODER_MAP_SVH
`define CMD_READ 3'h0
`define CMD_SET_MASK 3'h1
`define CMD_TEST 3'h2
`define CMD_CLEAR_INT_ACTIVE 3'h3
`define CMD_WRITE 3'h4
`define CMD_START 3'h5
`define CMD_CONTROL 3'h6
`define CMD_SET_INT 3'h7
// Control word bits, as indices with bit 0 the least significant.
`define CW_MASTER_CLEAR 15
`define CW_CLEAR_ALL 14
`define CW_SEL_CLR_HI 13
`define CW_SEL_CLR_LO 11
`define CW_INITIATE 10
`define CW_DEV_CTL_HI 9
`define CW_DEV_CTL_LO 5
`define CW_XFER_INT 4
`define CW_STATUS_SEL 3
`define CW_BYTE_MODE 2
`define CW_INT_ENABLE 1
// Status word bits.
`define SW_START_OK 15
`define SW_RW_OK 14
`define SW_PENDING 13
`define SW_SEQ_HI 12
`define SW_SEQ_LO 11
`define SW_DEV_FLAG 10
// Interrupt status byte bits.
`define IS_SYSTEM 2
`define IS_XFER 4
`define CTL_RESET 16'h0000
`define MASK_RESET 1'b1
`endif

// >>> io_command_decoder_pkg.sv
// Types shared by the command decoder and its device transfer sequencer.
`default_nettype none
package io_command_decoder_pkg;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_STROBE, SEQ_RELEASE, SEQ_DONE} seq_state_t;
endpackage
`default_nettype wire

// >>> xfer_if.sv
// Handshake between the command decoder and the device transfer sequencer.
`timescale 1ns/1ns
`default_nettype none
interface xfer_if;
	import io_command_decoder_pkg::*;
	logic start_read;
	logic start_write;
	logic byte_mode;
	logic [15:0] wr_data;
	logic busy;
	logic done;
	logic [15:0] rd_data;
	seq_state_t seq;
	modport main (output start_read, output start_write, output byte_mode, output wr_data,
		input busy, input done, input rd_data, input seq);
	modport seq_side (input start_read, input start_write, input byte_mode, input wr_data,
		output busy, output done, output rd_data, output seq);
endinterface
`default_nettype wire

// >>> device_transfer_sequencer.sv
// Moves one word, or two bytes, between the card and the external device.
`timescale 1ns/1ns
`default_nettype none
module device_transfer_sequencer
	import io_command_decoder_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	xfer_if.seq_side xf,
	input wire logic i_dev_flag,
	input wire logic [15:0] i_dev_data,
	output logic o_dev_strobe,
	output logic [15:0] o_dev_data
);
	`include "io_command_decoder_map.svh"
	seq_state_t state_r;
	logic rd_r;
	logic byte_r;
	logic half_r;
	logic done_r;
	logic [15:0] wr_r;
	logic [15:0] buf_r;

	assign xf.busy = (state_r != SEQ_IDLE);
	assign xf.done = done_r;
	assign xf.rd_data = buf_r;
	assign xf.seq = state_r;

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			state_r <= SEQ_IDLE;
			rd_r <= 1'b0;
			byte_r <= 1'b0;
			half_r <= 1'b0;
			done_r <= 1'b0;
			wr_r <= 16'h0000;
			buf_r <= 16'h0000;
			o_dev_strobe <= 1'b0;
			o_dev_data <= 16'h0000;
		end
		else
		begin
			done_r <= 1'b0;
			case (state_r)
				SEQ_IDLE:
					if (xf.start_read || xf.start_write)
					begin
						rd_r <= xf.start_read;
						byte_r <= xf.byte_mode;
						half_r <= 1'b0;
						wr_r <= xf.wr_data;
						// In byte mode the high byte goes first, on the low eight lines.
						o_dev_data <= xf.byte_mode ? {8'h00, xf.wr_data[15:8]} : xf.wr_data;
						o_dev_strobe <= 1'b1;
						state_r <= SEQ_STROBE;
					end
				SEQ_STROBE:
					if (i_dev_flag)
					begin
						if (rd_r && !byte_r)
							buf_r <= i_dev_data;
						else if (rd_r && !half_r)
							buf_r[15:8] <= i_dev_data[7:0];
						else if (rd_r)
							buf_r[7:0] <= i_dev_data[7:0];
						o_dev_strobe <= 1'b0;
						state_r <= SEQ_RELEASE;
					end
				SEQ_RELEASE:
					if (!i_dev_flag)
					begin
						if (byte_r && !half_r)
						begin
							half_r <= 1'b1;
							o_dev_data <= {8'h00, wr_r[7:0]};
							o_dev_strobe <= 1'b1;
							state_r <= SEQ_STROBE;
						end
						else
							state_r <= SEQ_DONE;
					end
				SEQ_DONE:
				begin
					done_r <= 1'b1;
					state_r <= SEQ_IDLE;
				end
				default:
					state_r <= SEQ_IDLE;
			endcase
		end
	end

	a_second_byte: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(o_dev_strobe && half_r && !rd_r) |-> o_dev_data == {8'h00, wr_r[7:0]})
		else $error("second byte of a write is not the low byte");
	a_byte_pack: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(state_r == SEQ_STROBE && i_dev_flag && rd_r && byte_r && half_r)
		|=> buf_r == {$past(buf_r[15:8]), $past(i_dev_data[7:0])})
		else $error("second input byte not packed into the low half");
endmodule
`default_nettype wire

// >>> io_command_decoder.sv
// Decodes direct commands and channel orders for the parallel device interface card.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Control command loads all sixteen control bits.
// - Read returns input buffer only when ready.
// - Fetch one word or two packed bytes.
// - Set-interrupt sets system bit; request gated.
// - Start command hands control to channel.
// - Set-mask enables interrupts by jumper group.
// - Test command returns the status word.
// - Write rejected while ready bit low.
// - Accepted write sends word or two bytes.
// - Selected card answers with service-in.
// - Command codes decode per fixed table.
// - Clear-interrupt resets active state only.
// - Control order reloads full control word.
// - End order returns the status word.
// - Interrupt order sets system interrupt only.
// - Device side identical for both modes.
// - Jumpers fix select, priority, group, parity.
// - Ready bit low during any transfer.
// - Interrupt enable bit gates every request.
module io_command_decoder
	import io_command_decoder_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [2:0] i_command_code,
	input wire logic [7:0] i_card_select_number,
	input wire logic i_service_out,
	input wire logic [15:0] i_data_out,
	input wire logic i_chan_control,
	input wire logic i_chan_end,
	input wire logic i_chan_interrupt,
	input wire logic i_chan_read,
	input wire logic i_chan_sense,
	input wire logic i_chan_write,
	input wire logic i_int_ack,
	input wire logic [7:0] i_jumper_select,
	input wire logic [3:0] i_jumper_mask_group,
	input wire logic [3:0] i_jumper_priority,
	input wire logic i_jumper_parity,
	input wire logic i_dev_flag,
	input wire logic [15:0] i_dev_data,
	input wire logic [7:0] i_dev_status,
	output logic o_service_in,
	output logic [15:0] o_data_in,
	output logic o_data_valid,
	output logic o_reject,
	output logic o_irq_request,
	output logic o_channel_active,
	output logic [3:0] o_priority,
	output logic o_dispatch_parity,
	output logic [4:0] o_dev_control,
	output logic o_dev_strobe,
	output logic [15:0] o_dev_data
);
	`include "io_command_decoder_map.svh"
	xfer_if xf ();
	logic [15:0] ctl_r;
	logic [7:0] int_stat_r;
	logic int_active_r;
	logic mask_en_r;
	logic chan_active_r;
	logic cmd_take;
	logic dir;
	logic do_ctl;
	logic do_rd;
	logic do_wr;
	logic do_sense;
	logic do_setint;
	logic do_mask;
	logic do_clrint;
	logic do_start;
	logic rw_ok;
	logic pending;
	logic [7:0] set_v;
	logic [7:0] clr_v;
	logic [15:0] status_w;

	// A command is taken only by this card, with the qualifier up and the last answer released.
	assign cmd_take = i_service_out && (i_card_select_number == i_jumper_select) && !o_service_in;
	// While the channel owns the card, direct data and control commands are ignored.
	assign dir = cmd_take && !chan_active_r;
	assign do_ctl = (dir && i_command_code == `CMD_CONTROL) || (i_chan_control && chan_active_r);
	assign do_rd = (dir && i_command_code == `CMD_READ) || (i_chan_read && chan_active_r);
	assign do_wr = (dir && i_command_code == `CMD_WRITE) || (i_chan_write && chan_active_r);
	assign do_sense = (cmd_take && i_command_code == `CMD_TEST)
		|| (chan_active_r && (i_chan_sense || i_chan_end));
	assign do_setint = (cmd_take && i_command_code == `CMD_SET_INT)
		|| (i_chan_interrupt && chan_active_r);
	assign do_mask = cmd_take && i_command_code == `CMD_SET_MASK;
	assign do_clrint = cmd_take && i_command_code == `CMD_CLEAR_INT_ACTIVE;
	assign do_start = cmd_take && i_command_code == `CMD_START && !chan_active_r;
	assign rw_ok = !xf.busy;
	assign pending = |int_stat_r;
	assign status_w = {!chan_active_r, rw_ok, pending, xf.seq, i_dev_flag, 2'b00,
		ctl_r[`CW_STATUS_SEL] ? i_dev_status : int_stat_r};

	// Initiate bit fetches the next input word; a write is passed on only when ready.
	assign xf.start_read = do_ctl && i_data_out[`CW_INITIATE] && rw_ok;
	assign xf.start_write = do_wr && rw_ok;
	assign xf.byte_mode = do_ctl ? i_data_out[`CW_BYTE_MODE] : ctl_r[`CW_BYTE_MODE];
	assign xf.wr_data = i_data_out;

	device_transfer_sequencer u_seq (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.xf(xf.seq_side),
		.i_dev_flag(i_dev_flag),
		.i_dev_data(i_dev_data),
		.o_dev_strobe(o_dev_strobe),
		.o_dev_data(o_dev_data)
	);

	always_comb
	begin
		set_v = 8'h00;
		set_v[`IS_SYSTEM] = do_setint;
		set_v[`IS_XFER] = xf.done && ctl_r[`CW_XFER_INT];
		clr_v = 8'h00;
		if (do_ctl && (i_data_out[`CW_MASTER_CLEAR] || i_data_out[`CW_CLEAR_ALL]))
			clr_v = 8'hff;
		else if (do_ctl)
		begin
			case (i_data_out[`CW_SEL_CLR_HI:`CW_SEL_CLR_LO])
				3'h1: clr_v = 8'h03;
				3'h2: clr_v = 8'h04;
				3'h3: clr_v = 8'h08;
				3'h4: clr_v = 8'h10;
				3'h5: clr_v = 8'h80;
				3'h6: clr_v = 8'h40;
				3'h7: clr_v = 8'h20;
				default: clr_v = 8'h00;
			endcase
		end
	end

	// Control word: every load replaces all bits.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			ctl_r <= `CTL_RESET;
		else if (do_ctl)
			ctl_r <= i_data_out;
	end

	// Interrupt status: a set in the same cycle as a clear wins.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			int_stat_r <= 8'h00;
		else
			int_stat_r <= (int_stat_r & ~clr_v) | set_v;
	end

	// Interrupt active: set when the host takes the request, cleared by the clear command or by a master clear in the control word.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			int_active_r <= 1'b0;
		else if (i_int_ack && o_irq_request)
			int_active_r <= 1'b1;
		else if (do_clrint || (do_ctl && i_data_out[`CW_MASTER_CLEAR]))
			int_active_r <= 1'b0;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			mask_en_r <= `MASK_RESET;
		else if (do_mask)
			mask_en_r <= i_data_out[i_jumper_mask_group];
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			o_irq_request <= 1'b0;
		else
			o_irq_request <= pending && ctl_r[`CW_INT_ENABLE] && mask_en_r && !int_active_r;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			chan_active_r <= 1'b0;
		else if (do_start)
			chan_active_r <= 1'b1;
		else if (i_chan_end && chan_active_r)
			chan_active_r <= 1'b0;
	end

	// Service-in rises on a taken command and falls once service-out is withdrawn.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
			o_service_in <= 1'b0;
		else if (cmd_take)
			o_service_in <= 1'b1;
		else if (!i_service_out)
			o_service_in <= 1'b0;
	end

	// Data toward the host: input buffer on a ready read, status on test, sense or end.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_data_in <= 16'h0000;
			o_data_valid <= 1'b0;
			o_reject <= 1'b0;
		end
		else
		begin
			o_data_valid <= (do_rd && rw_ok) || do_sense;
			o_reject <= (do_rd || do_wr) && !rw_ok;
			if (do_rd && rw_ok)
				o_data_in <= xf.rd_data;
			else if (do_sense)
				o_data_in <= status_w;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_channel_active <= 1'b0;
			o_priority <= 4'h0;
			o_dispatch_parity <= 1'b0;
			o_dev_control <= 5'h00;
		end
		else
		begin
			o_channel_active <= chan_active_r;
			o_priority <= i_jumper_priority;
			o_dispatch_parity <= i_jumper_parity;
			o_dev_control <= ctl_r[`CW_DEV_CTL_HI:`CW_DEV_CTL_LO];
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence s_cmd_taken;
		cmd_take;
	endsequence
	sequence s_held_released;
		o_service_in [*1] ##0 !i_service_out ##1 !o_service_in;
	endsequence

	a_control_load: assert property (do_ctl |=> ctl_r == $past(i_data_out))
		else $error("control word not fully reloaded");
	a_read_data: assert property (do_rd && rw_ok |=> o_data_valid && o_data_in == $past(xf.rd_data))
		else $error("ready read did not return the input buffer");
	a_read_block: assert property (do_rd && !rw_ok && !do_sense |=> !o_data_valid && o_reject)
		else $error("read answered while not ready");
	a_set_system: assert property (do_setint |=> int_stat_r[`IS_SYSTEM])
		else $error("system interrupt bit not set");
	a_irq_gated: assert property (o_irq_request |-> $past(ctl_r[`CW_INT_ENABLE] && mask_en_r && !int_active_r))
		else $error("interrupt request without enable");
	a_mask_take: assert property (do_mask |=> mask_en_r == $past(i_data_out[i_jumper_mask_group]))
		else $error("mask group bit not taken");
	a_test_status: assert property (cmd_take && i_command_code == `CMD_TEST
		|=> o_data_valid && o_data_in == $past(status_w))
		else $error("test command did not return status");
	a_write_reject: assert property (do_wr && !rw_ok |-> !xf.start_write ##1 o_reject)
		else $error("write not rejected while busy");
	a_ack_raise: assert property (s_cmd_taken |=> o_service_in)
		else $error("selected card did not answer");
	a_ack_hold: assert property (o_service_in && i_service_out |=> o_service_in)
		else $error("service-in dropped before service-out");
	a_ack_release: assert property (o_service_in && !i_service_out |-> s_held_released)
		else $error("service-in held after service-out fell");
	a_ignore_other: assert property (!o_service_in && (i_card_select_number != i_jumper_select
		|| !i_service_out) |=> !o_service_in)
		else $error("answered a command for another card");
	a_clear_active: assert property (do_clrint && !(i_int_ack && o_irq_request)
		|=> !int_active_r && ((int_stat_r & $past(int_stat_r)) == $past(int_stat_r)))
		else $error("clear interrupt active lost a latched cause");
	a_start_chan: assert property (do_start |=> chan_active_r ##1 o_channel_active)
		else $error("start command did not hand over to channel");
	a_end_status: assert property (chan_active_r && i_chan_end
		|=> o_data_valid && o_data_in == $past(status_w) && !chan_active_r)
		else $error("end order did not return status");
	a_busy_rwok: assert property (cmd_take && i_command_code == `CMD_TEST && xf.busy
		|=> o_data_valid && !o_data_in[`SW_RW_OK])
		else $error("ready bit high during transfer");
	a_strobe_busy: assert property (o_dev_strobe |-> !rw_ok)
		else $error("device strobe while ready");
	// Direct control commands are answered but not acted on while the channel owns the card.
	a_direct_ignored: assert property (cmd_take && chan_active_r && !i_chan_control
		&& i_command_code == `CMD_CONTROL |=> ctl_r == $past(ctl_r))
		else $error("direct control taken while channel active");
	a_mask_hold: assert property (!do_mask |=> mask_en_r == $past(mask_en_r))
		else $error("mask enable changed without a set-mask command");
endmodule
`default_nettype wire

// >>> dev_partner_model.sv
// Behavioural model of the external device that answers the card's transfer strobe.
`timescale 1ns/1ns
`default_nettype none
module dev_partner_model
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_strobe,
	input wire logic [15:0] i_data,
	input wire logic [15:0] i_give,
	input wire logic i_slow,
	output logic o_flag,
	output logic [15:0] o_data,
	output logic [7:0] o_cnt,
	output logic [15:0] o_last,
	output logic [15:0] o_prev
);
	logic [3:0] wait_r;
	logic due;
	assign due = !i_slow || wait_r == 4'hb;
	// Released data is inverted so that a stale word can never be mistaken for a fresh one.
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			o_flag <= 1'b0;
			o_data <= 16'h5a5a;
			o_cnt <= 8'h0;
			o_last <= 16'h0;
			o_prev <= 16'h0;
			wait_r <= 4'h0;
		end
		else if (o_flag != i_strobe)
		begin
			wait_r <= due ? 4'h0 : wait_r + 4'h1;
			if (due && i_strobe)
			begin
				o_flag <= 1'b1;
				o_data <= i_give ^ {16{o_cnt[0]}};
				o_cnt <= o_cnt + 8'h1;
				o_last <= i_data;
				o_prev <= o_last;
			end
			else if (due)
			begin
				o_flag <= 1'b0;
				o_data <= ~o_data;
			end
		end
		else
			wait_r <= 4'h0;
	end
endmodule
`default_nettype wire

// >>> io_command_decoder_bench.sv
// Self-checking bench for the direct command and channel order decoder.
`timescale 1ns/1ns
`default_nettype none
`include "io_command_decoder_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module io_command_decoder_bench
	import io_command_decoder_pkg::*;
;
	localparam logic [7:0] jsel = 8'h2a;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] code = 3'h0;
	logic [7:0] sel = 8'h0;
	logic so = 1'b0;
	logic [15:0] dout = 16'h0;
	logic [5:0] chs = 6'h0;
	logic ack = 1'b0;
	logic [7:0] dst = 8'h0;
	logic [15:0] give = 16'h0;
	logic slow = 1'b0;
	logic si, dv, rjo, irq, cha, par, dstb, pflag, vld, rej;
	logic [15:0] din, ddat, pdat, plast, pprev, rd;
	logic [3:0] pri;
	logic [4:0] dctl;
	logic [7:0] pcnt;
	int failures = 0;
	int n_checks = 0;
	int seed = 32'hb8d4;
	io_command_decoder i_dut (.i_core_clk(clk), .i_reset(rst), .i_command_code(code), .i_card_select_number(sel),
		.i_service_out(so), .i_data_out(dout), .i_chan_control(chs[5]), .i_chan_end(chs[4]),
		.i_chan_interrupt(chs[3]), .i_chan_read(chs[2]), .i_chan_sense(chs[1]), .i_chan_write(chs[0]),
		.i_int_ack(ack), .i_jumper_select(jsel), .i_jumper_mask_group(4'h3), .i_jumper_priority(4'h5),
		.i_jumper_parity(1'b1), .i_dev_flag(pflag), .i_dev_data(pdat), .i_dev_status(dst), .o_service_in(si),
		.o_data_in(din), .o_data_valid(dv), .o_reject(rjo), .o_irq_request(irq), .o_channel_active(cha),
		.o_priority(pri), .o_dispatch_parity(par), .o_dev_control(dctl), .o_dev_strobe(dstb), .o_dev_data(ddat));
	dev_partner_model i_dev (.i_core_clk(clk), .i_reset(rst), .i_strobe(dstb), .i_data(ddat), .i_give(give),
		.i_slow(slow), .o_flag(pflag), .o_data(pdat), .o_cnt(pcnt), .o_last(plast), .o_prev(pprev));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [15:0] d);
		int k;
		@(posedge clk);
		code <= c;
		sel <= jsel;
		so <= 1'b1;
		dout <= d;
		k = 0;
		do
		begin
			tick(1);
			k++;
		end
		while (si !== 1'b1 && k < 20);
		`CHK(si, 1'b1)
		rd = din;
		vld = dv;
		rej = rjo;
		tick(1);
		`CHK(si, 1'b1)
		@(posedge clk);
		so <= 1'b0;
		k = 0;
		do
		begin
			tick(1);
			k++;
		end
		while (si !== 1'b0 && k < 20);
		`CHK(si, 1'b0)
	endtask
	task automatic chan(input int b, input logic [15:0] d);
		@(posedge clk);
		chs <= 6'h1 << b;
		dout <= d;
		@(posedge clk);
		chs <= 6'h0;
		#1;
		rd = din;
		vld = dv;
	endtask
	task automatic wait_ready;
		int k;
		k = 0;
		do
		begin
			cmd(`CMD_TEST, 16'h0);
			k++;
		end
		while (rd[`SW_RW_OK] !== 1'b1 && k < 30);
		`CHK(rd[`SW_RW_OK], 1'b1)
	endtask
	function automatic logic [15:0] exp_rd(input logic [15:0] g, input logic [7:0] c0, input logic bm);
		logic [15:0] a;
		logic [15:0] b;
		a = g ^ {16{c0[0]}};
		b = g ^ {16{~c0[0]}};
		exp_rd = bm ? {a[7:0], b[7:0]} : a;
	endfunction
	// The watchdog allows more than a hundred times the expected length of the whole run.
	initial
	begin
		#1000000;
		failures++;
		test_done;
	end
	initial
	begin
		logic [15:0] d;
		logic [7:0] c0;
		dst <= 8'($random(seed));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		`CHK({si, dv, rjo, irq, cha, dstb}, 6'h0)
		`CHK({pri, par}, 5'h0b)
		cmd(`CMD_TEST, 16'h0);
		`CHK(vld, 1'b1)
		`CHK(rd, 16'hc000)
		d = 16'($random(seed));
		d = d & 16'h03e8;
		cmd(`CMD_CONTROL, d);
		`CHK(dctl, d[9:5])
		cmd(`CMD_TEST, 16'h0);
		`CHK(rd, {8'hc0, d[3] ? dst : 8'h00})
		cmd(`CMD_CONTROL, 16'h0);
		`CHK(dctl, 5'h0)
		@(posedge clk);
		sel <= ~jsel;
		code <= `CMD_TEST;
		so <= 1'b1;
		@(posedge clk);
		sel <= jsel;
		so <= 1'b0;
		repeat (4)
		begin
			tick(1);
			`CHK({si, dv}, 2'h0)
		end
		cmd(`CMD_CONTROL, 16'h0002);
		cmd(`CMD_SET_INT, 16'h0);
		tick(2);
		`CHK(irq, 1'b1)
		cmd(`CMD_TEST, 16'h0);
		`CHK(rd, 16'he004)
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		tick(2);
		`CHK(irq, 1'b0)
		cmd(`CMD_CLEAR_INT_ACTIVE, 16'h0);
		tick(2);
		`CHK(irq, 1'b1)
		cmd(`CMD_TEST, 16'h0);
		`CHK(rd[`IS_SYSTEM], 1'b1)
		cmd(`CMD_CONTROL, 16'h4000);
		cmd(`CMD_SET_INT, 16'h0);
		tick(2);
		`CHK(irq, 1'b0)
		cmd(`CMD_CONTROL, 16'h4000);
		cmd(`CMD_SET_MASK, 16'hfff7);
		cmd(`CMD_CONTROL, 16'h0002);
		cmd(`CMD_SET_INT, 16'h0);
		tick(2);
		`CHK(irq, 1'b0)
		cmd(`CMD_SET_MASK, 16'h0008);
		tick(2);
		`CHK(irq, 1'b1)
		cmd(`CMD_CONTROL, 16'h4000);
		for (int bm = 0; bm < 2; bm++)
		begin
			d = 16'($random(seed));
			slow <= 1'b1;
			cmd(`CMD_CONTROL, {13'h0, bm[0], 2'h0});
			cmd(`CMD_WRITE, d);
			`CHK(rej, 1'b0)
			cmd(`CMD_TEST, 16'h0);
			`CHK(rd[`SW_RW_OK], 1'b0)
			cmd(`CMD_WRITE, ~d);
			`CHK(rej, 1'b1)
			wait_ready;
			`CHK(bm ? {pprev[7:0], plast[7:0]} : plast, d)
			d = 16'($random(seed));
			give <= d;
			slow <= bm[0];
			c0 = pcnt;
			cmd(`CMD_CONTROL, {5'h0, 1'b1, 7'h0, bm[0], 2'h0});
			wait_ready;
			cmd(`CMD_READ, 16'h0);
			`CHK(vld, 1'b1)
			`CHK(rd, exp_rd(d, c0, bm[0]))
		end
		slow <= 1'b1;
		cmd(`CMD_CONTROL, 16'h0400);
		cmd(`CMD_READ, 16'h0);
		`CHK(rej, 1'b1)
		wait_ready;
		cmd(`CMD_CONTROL, 16'h0);
		cmd(`CMD_START, 16'h0);
		tick(2);
		`CHK(cha, 1'b1)
		cmd(`CMD_CONTROL, 16'h03e0);
		`CHK(dctl, 5'h0)
		chan(5, 16'h0140);
		tick(2);
		`CHK(dctl, 5'h0a)
		chan(3, 16'h0);
		`CHK(dstb, 1'b0)
		chan(1, 16'h0);
		`CHK(vld, 1'b1)
		`CHK(rd, 16'h6004)
		d = 16'($random(seed));
		slow <= 1'b0;
		chan(0, d);
		wait_ready;
		`CHK(plast, d)
		chan(4, 16'h0);
		`CHK({vld, rd[`IS_SYSTEM]}, 2'h3)
		tick(3);
		`CHK(cha, 1'b0)
		test_done;
	end
endmodule
`default_nettype wire
